/* verilog/osdm_map.vh */
`ifndef OSDM_MAP_VH
`define OSDM_MAP_VH

// ------------------------------------------------------------
// bus address
// ------------------------------------------------------------
`define OSDM_SLAVE_ADDR 7'h5D
`define OSDM_RW_BIT 0

// ------------------------------------------------------------
// memory map
// ------------------------------------------------------------
`define OSDM_FONT2_LO 16'h0000
`define OSDM_FONT2_HI 16'h2FFF
`define OSDM_FONT4_LO 16'h3000
`define OSDM_FONT4_HI 16'h3FFF
`define OSDM_PAGE_LO 16'h8000
`define OSDM_PAGE_HI 16'h81FF
`define OSDM_ATTR_LO 16'h8200
`define OSDM_ATTR_HI 16'h83FF
`define OSDM_FACC_ADDR 16'h8402
`define OSDM_FACC_RESET 2'h0

// ------------------------------------------------------------
// font address fields
// ------------------------------------------------------------
`define OSDM_CHAR_MSB 13
`define OSDM_CHAR_LSB 6
`define OSDM_ROW_MSB 5
`define OSDM_ROW_LSB 1
`define OSDM_HALF_BIT 0
`define OSDM_ROW_MAX 5'h11

// ------------------------------------------------------------
// page entry layout
// ------------------------------------------------------------
`define OSDM_ENTRY_W 12
`define OSDM_PAGE_AW 9
`define OSDM_ATTR_MSB 11
`define OSDM_ATTR_LSB 8

// ------------------------------------------------------------
// region codes
// ------------------------------------------------------------
`define OSDM_RG_FONT2 3'h0
`define OSDM_RG_FONT4 3'h1
`define OSDM_RG_CODE 3'h2
`define OSDM_RG_ATTR 3'h3
`define OSDM_RG_FACC 3'h4
`define OSDM_RG_NONE 3'h5

`endif

/* verilog/osdm_page_ram.v */
`timescale 1ns/1ps
`default_nettype none
`include "osdm_map.vh"

module osdm_page_ram #(
   parameter AW = `OSDM_PAGE_AW,
   parameter DW = `OSDM_ENTRY_W
) (
   // clock
   input wire clock,
   // serial port side
   input wire [AW-1:0] a_addr,
   input wire a_we_code,
   input wire a_we_attr,
   input wire [7:0] a_wdata,
   output reg [DW-1:0] a_rdata,
   // display side
   input wire [AW-1:0] b_addr,
   output reg [DW-1:0] b_rdata
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   // code and attribute halves written separately
   always @(posedge clock) begin
      if (a_we_code) begin
         mem[a_addr][7:0] <= a_wdata;
      end
      if (a_we_attr) begin
         mem[a_addr][DW-1:8] <= a_wdata[DW-9:0];
      end
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
   end

endmodule

`default_nettype wire

/* verilog/osdm_i2c_port.v */
// Operation
// [R1] respond to bus address byte BA for write and BB for read
// [R2] first byte: bits 7..1 slave address, bit 0 direction, low means write
// [R3] master opens each transfer with a start: data falls while clock high
// [R4] after each byte master releases data; receiver pulls it low to acknowledge
// [R5] write: two register address bytes follow, low byte first, forming 16 bits
// [R6] accept data bytes, store each at current address, then increment address
// [R7] master reads after an address-only write ended by stop, then new transfer
// [R8] read: send eight bits from loaded address, increment per further byte
// [R9] master should read only while both display windows are disabled
// [R10] two-colour font store read-only at 0000-2FFF, 192 fonts
// [R11] font address bits 15,14 zero; bits 13..6 select character 00-BF
// [R12] four-colour font store read-only at 3000-3FFF, characters C0-FF
// [R13] font address bits 5..1 select pixel row; rows 00-11 valid
// [R14] font address bit 0 picks low or high half of the row
// [R15] low byte holds first eight pixels, bit 0 leftmost
// [R16] high byte holds last four pixels in bits 3..0, bit 3 rightmost
// [R17] bit 0 of register 8402 picks four-colour pixel plane
// [R18] read/write display page 8000-81FF holding 512 entries
// [R19] page entry is 12 bits: 8-bit code plus 4-bit attribute
// [R20] 4-bit attribute indexes one of 16 attribute table entries
// [R21] writes to read-only or reserved space are acknowledged and dropped
`timescale 1ns/1ps
`default_nettype none
`include "osdm_map.vh"

module osdm_i2c_port #(
   parameter PAGE_AW = `OSDM_PAGE_AW
) (
   // clock and reset
   input wire clock,
   input wire resetn,
   // two-wire link
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_n,
   // external font rom
   output reg [7:0] font_char,
   output reg [4:0] font_row,
   output reg font_plane,
   input wire [11:0] font_row_data,
   // display engine page read
   input wire [PAGE_AW-1:0] page_rd_addr,
   output wire [`OSDM_ENTRY_W-1:0] page_rd_data,
   output reg [3:0] page_rd_attr,
   // status
   output reg busy
);

   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam S_IDLE = 7'h01;
   localparam S_ADDR = 7'h02;
   localparam S_AACK = 7'h04;
   localparam S_RX = 7'h08;
   localparam S_RACK = 7'h10;
   localparam S_TX = 7'h20;
   localparam S_TACK = 7'h40;

   // ------------------------------------------------------------
   // region decode
   // ------------------------------------------------------------
   function [2:0] region;
      input [15:0] a;
      begin
         if (a <= `OSDM_FONT2_HI) begin
            region = `OSDM_RG_FONT2;
         end else if (a >= `OSDM_FONT4_LO && a <= `OSDM_FONT4_HI) begin
            region = `OSDM_RG_FONT4;
         end else if (a >= `OSDM_PAGE_LO && a <= `OSDM_PAGE_HI) begin
            region = `OSDM_RG_CODE;
         end else if (a >= `OSDM_ATTR_LO && a <= `OSDM_ATTR_HI) begin
            region = `OSDM_RG_ATTR;
         end else if (a == `OSDM_FACC_ADDR) begin
            region = `OSDM_RG_FACC;
         end else begin
            region = `OSDM_RG_NONE;
         end
      end
   endfunction

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   reg rst_m_ff;
   reg rst_n_ff;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_m_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_m_ff <= 1'b1;
         rst_n_ff <= rst_m_ff;
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers and edge finding
   // ------------------------------------------------------------
   reg scl_m_ff;
   reg scl_s_ff;
   reg scl_d_ff;
   reg sda_m_ff;
   reg sda_s_ff;
   reg sda_d_ff;

   always @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         scl_m_ff <= 1'b1;
         scl_s_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_m_ff <= 1'b1;
         sda_s_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_m_ff <= scl_in;
         scl_s_ff <= scl_m_ff;
         scl_d_ff <= scl_s_ff;
         sda_m_ff <= sda_in;
         sda_s_ff <= sda_m_ff;
         sda_d_ff <= sda_s_ff;
      end
   end

   wire scl_rise = scl_s_ff & ~scl_d_ff;
   wire scl_fall = ~scl_s_ff & scl_d_ff;
   // [R3] start detect
   wire start_det = scl_s_ff & scl_d_ff & ~sda_s_ff & sda_d_ff;
   wire stop_det = scl_s_ff & scl_d_ff & sda_s_ff & ~sda_d_ff;

   // ------------------------------------------------------------
   // protocol registers
   // ------------------------------------------------------------
   reg [6:0] state_ff;
   reg [3:0] bit_cnt_ff;
   reg [7:0] rx_ff;
   reg [7:0] tx_ff;
   reg [1:0] byte_idx_ff;
   reg [15:0] addr_ff;
   reg rw_ff;
   reg master_ack_ff;
   reg [1:0] facc_ff;
   reg wr_code_ff;
   reg wr_attr_ff;
   reg [PAGE_AW-1:0] wr_addr_ff;
   reg [7:0] wr_data_ff;
   wire [`OSDM_ENTRY_W-1:0] page_a_rdata;

   // ------------------------------------------------------------
   // read byte assembly
   // ------------------------------------------------------------
   reg [7:0] nxt_tx_byte;
   reg [2:0] rd_region;

   always @* begin
      rd_region = region(addr_ff);
      nxt_tx_byte = 8'h00;
      case (rd_region)
         `OSDM_RG_FONT2, `OSDM_RG_FONT4: begin
            // [R13] rows past the last read as zero
            if (addr_ff[`OSDM_ROW_MSB:`OSDM_ROW_LSB] <= `OSDM_ROW_MAX) begin
               // [R14] half select
               if (addr_ff[`OSDM_HALF_BIT]) begin
                  // [R16] last four pixels, upper bits zero
                  nxt_tx_byte = {4'h0, font_row_data[11:8]};
               end else begin
                  // [R15] first eight pixels, leftmost in bit 0
                  nxt_tx_byte = font_row_data[7:0];
               end
            end
         end
         `OSDM_RG_CODE: begin
            // [R19] character code half
            nxt_tx_byte = page_a_rdata[7:0];
         end
         `OSDM_RG_ATTR: begin
            nxt_tx_byte = {4'h0, page_a_rdata[`OSDM_ATTR_MSB:`OSDM_ATTR_LSB]};
         end
         `OSDM_RG_FACC: begin
            nxt_tx_byte = {6'h00, facc_ff};
         end
         default: begin
            nxt_tx_byte = 8'h00;
         end
      endcase
   end

   // ------------------------------------------------------------
   // write decode of a finished data byte
   // ------------------------------------------------------------
   reg [2:0] wr_region;

   always @* begin
      wr_region = region(addr_ff);
   end

   // ------------------------------------------------------------
   // protocol engine
   // ------------------------------------------------------------
   always @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         state_ff <= S_IDLE;
         bit_cnt_ff <= 4'h0;
         rx_ff <= 8'h00;
         tx_ff <= 8'h00;
         byte_idx_ff <= 2'h0;
         addr_ff <= 16'h0000;
         rw_ff <= 1'b0;
         master_ack_ff <= 1'b0;
         facc_ff <= `OSDM_FACC_RESET;
         wr_code_ff <= 1'b0;
         wr_attr_ff <= 1'b0;
         wr_addr_ff <= {PAGE_AW{1'b0}};
         wr_data_ff <= 8'h00;
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         wr_code_ff <= 1'b0;
         wr_attr_ff <= 1'b0;
         if (start_det) begin
            state_ff <= S_ADDR;
            bit_cnt_ff <= 4'h0;
            byte_idx_ff <= 2'h0;
            sda_oe_n <= 1'b1;
         end else if (stop_det) begin
            state_ff <= S_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            case (state_ff)
               S_ADDR, S_RX: begin
                  if (scl_rise) begin
                     rx_ff <= {rx_ff[6:0], sda_s_ff};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                     if (state_ff == S_ADDR) begin
                        // [R1] [R2] match address, note direction
                        if (rx_ff[7:1] == `OSDM_SLAVE_ADDR) begin
                           rw_ff <= rx_ff[`OSDM_RW_BIT];
                           state_ff <= S_AACK;
                           // [R4] acknowledge byte
                           sda_oe_n <= 1'b0;
                        end else begin
                           state_ff <= S_IDLE;
                        end
                     end else begin
                        state_ff <= S_RACK;
                        sda_oe_n <= 1'b0;
                        // [R5] low address byte then high
                        if (byte_idx_ff == 2'h0) begin
                           addr_ff[7:0] <= rx_ff;
                           byte_idx_ff <= 2'h1;
                        end else if (byte_idx_ff == 2'h1) begin
                           addr_ff[15:8] <= rx_ff;
                           byte_idx_ff <= 2'h2;
                        end else begin
                           // [R6] store then advance
                           addr_ff <= addr_ff + 16'h0001;
                           wr_addr_ff <= addr_ff[PAGE_AW-1:0];
                           wr_data_ff <= rx_ff;
                           // [R18] page code store writable
                           wr_code_ff <= (wr_region == `OSDM_RG_CODE);
                           wr_attr_ff <= (wr_region == `OSDM_RG_ATTR);
                           // [R17] plane select register
                           if (wr_region == `OSDM_RG_FACC) begin
                              facc_ff <= rx_ff[1:0];
                           end
                           // [R21] font and reserved writes dropped
                        end
                     end
                  end
               end
               S_AACK, S_RACK: begin
                  if (scl_fall) begin
                     bit_cnt_ff <= 4'h0;
                     if (state_ff == S_AACK && rw_ff) begin
                        // [R8] first byte from loaded address
                        state_ff <= S_TX;
                        tx_ff <= {nxt_tx_byte[6:0], 1'b0};
                        sda_oe_n <= nxt_tx_byte[7];
                        addr_ff <= addr_ff + 16'h0001;
                     end else begin
                        state_ff <= S_RX;
                        sda_oe_n <= 1'b1;
                     end
                  end
               end
               S_TX: begin
                  if (scl_rise) begin
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt_ff == 4'h8) begin
                        // [R4] release for master acknowledge
                        state_ff <= S_TACK;
                        sda_oe_n <= 1'b1;
                     end else begin
                        tx_ff <= {tx_ff[6:0], 1'b0};
                        sda_oe_n <= tx_ff[7];
                     end
                  end
               end
               S_TACK: begin
                  if (scl_rise) begin
                     master_ack_ff <= ~sda_s_ff;
                  end else if (scl_fall) begin
                     bit_cnt_ff <= 4'h0;
                     if (master_ack_ff) begin
                        // [R8] next byte, address advances
                        state_ff <= S_TX;
                        tx_ff <= {nxt_tx_byte[6:0], 1'b0};
                        sda_oe_n <= nxt_tx_byte[7];
                        addr_ff <= addr_ff + 16'h0001;
                     end else begin
                        state_ff <= S_IDLE;
                     end
                  end
               end
               S_IDLE: begin
                  sda_oe_n <= 1'b1;
               end
               default: begin
                  state_ff <= S_IDLE;
                  sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // font rom address and status outputs
   // ------------------------------------------------------------
   always @(posedge clock or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         font_char <= 8'h00;
         font_row <= 5'h00;
         font_plane <= 1'b0;
         busy <= 1'b0;
         page_rd_attr <= 4'h0;
      end else begin
         // [R11] [R10] [R12] character from address bits
         font_char <= addr_ff[`OSDM_CHAR_MSB:`OSDM_CHAR_LSB];
         font_row <= addr_ff[`OSDM_ROW_MSB:`OSDM_ROW_LSB];
         // [R17] plane only matters in four-colour space
         font_plane <= facc_ff[0] & (rd_region == `OSDM_RG_FONT4);
         busy <= (state_ff != S_IDLE);
         // [R20] attribute index for table lookup
         page_rd_attr <= page_rd_data[`OSDM_ATTR_MSB:`OSDM_ATTR_LSB];
      end
   end

   // ------------------------------------------------------------
   // page store
   // ------------------------------------------------------------
   wire wr_any = wr_code_ff | wr_attr_ff;
   // write address wins for its single cycle; pointer has moved on
   wire [PAGE_AW-1:0] page_a_addr = wr_any ? wr_addr_ff : addr_ff[PAGE_AW-1:0];

   // [R18] [R19] 512 entries of 12 bits
   osdm_page_ram #(
      .AW(PAGE_AW),
      .DW(`OSDM_ENTRY_W)
   ) u_page (
      .clock(clock),
      .a_addr(page_a_addr),
      .a_we_code(wr_code_ff),
      .a_we_attr(wr_attr_ff),
      .a_wdata(wr_data_ff),
      .a_rdata(page_a_rdata),
      .b_addr(page_rd_addr),
      .b_rdata(page_rd_data)
   );

endmodule

`default_nettype wire

/* testbench/osdm_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "osdm_map.vh"
module osdm_port_sva (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // two-wire link
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // page and status
   input wire logic [`OSDM_ENTRY_W-1:0] page_rd_data,
   input wire logic [3:0] page_rd_attr,
   input wire logic busy
);
   // ------------------------------------------------------------
   // helper: clocks since the bus clock went low
   // ------------------------------------------------------------
   logic [3:0] low_cnt_ff;
   // saturates so a stalled bus never wraps into the legal window
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         low_cnt_ff <= 4'h0;
      end else if (scl_in) begin
         low_cnt_ff <= 4'h0;
      end else if (low_cnt_ff != 4'hF) begin
         low_cnt_ff <= low_cnt_ff + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // helper: reset seen at the previous edge
   // ------------------------------------------------------------
   // first edge of reset only just loads the outputs, so judge from the next one
   logic rst_old_ff = 1'b0;
   always_ff @(posedge clock) begin
      rst_old_ff <= !resetn;
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_out_low: assert property (sda_out == 1'b0)
      else $error("data pin value not low");
   a_idle_quiet: assert property (!busy |-> sda_oe_n)
      else $error("data pin driven while idle");
   a_edge_window: assert property ($changed(sda_oe_n) |-> !scl_in && low_cnt_ff inside {[2:6]})
      else $error("data pin changed outside low clock window");
   a_ack_hold: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
      else $error("driven low bit released too early");
   a_busy_start: assert property ($fell(sda_in) && scl_in |-> ##[1:6] busy)
      else $error("start not taken");
   a_stop_idle: assert property ($rose(sda_in) && scl_in |-> ##[1:6] !busy)
      else $error("stop did not return to idle");
   a_attr_follow: assert property ($past(resetn, 4) |-> page_rd_attr === $past(page_rd_data[11:8]))
      else $error("attribute output does not follow page entry");
   a_reset_quiet: assert property (disable iff (1'b0) rst_old_ff && !resetn |-> sda_oe_n && !busy)
      else $error("outputs active during reset");

   c_start: cover property ($rose(busy));
   c_drive: cover property ($fell(sda_oe_n));
   c_stop: cover property ($fell(busy));
endmodule

bind osdm_i2c_port osdm_port_sva u_sva (
   .clock(clock),
   .resetn(resetn),
   .scl_in(scl_in),
   .sda_in(sda_in),
   .sda_out(sda_out),
   .sda_oe_n(sda_oe_n),
   .page_rd_data(page_rd_data),
   .page_rd_attr(page_rd_attr),
   .busy(busy)
);
`default_nettype wire

/* testbench/osdm_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module osdm_master_model (
   // pacing clock
   input wire logic clock,
   // resolved data line
   input wire logic sda_line,
   // open-drain outputs, 1 = released
   output logic scl,
   output logic sda_rel
);
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end

   // four clocks are a quarter of the 64 ns bus period
   task automatic tk(input int n);
      repeat (n) @(negedge clock);
   endtask

   // start: data falls with clock high
   task automatic start();
      sda_rel = 1'b1;
      tk(4);
      scl = 1'b1;
      tk(4);
      sda_rel = 1'b0;
      tk(4);
      scl = 1'b0;
      tk(4);
   endtask

   task automatic stop();
      sda_rel = 1'b0;
      tk(4);
      scl = 1'b1;
      tk(4);
      sda_rel = 1'b1;
      tk(8);
   endtask

   // sample in mid high phase, well clear of both edges
   task automatic bit_io(input logic b, output logic s);
      sda_rel = b;
      tk(4);
      scl = 1'b1;
      tk(4);
      s = sda_line;
      tk(4);
      scl = 1'b0;
      tk(4);
   endtask

   // ninth bit released for the receiver
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask

   // master pulls low to ask for more
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(last, s);
   endtask
endmodule
`default_nettype wire

/* testbench/osd_i2c_memory_access_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module osd_i2c_memory_access_port_tb;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic scl, sda_rel, sda_out, sda_oe_n, font_plane, busy;
   logic [7:0] font_char;
   logic [4:0] font_row;
   logic [8:0] page_rd_addr = 9'h000;
   logic [11:0] page_rd_data;
   logic [3:0] page_rd_attr;
   wire sda_line;
   wire [11:0] font_row_data;
   int miscompares = 0;
   int check_count = 0;

   always #2 clock = ~clock;
   assign sda_line = sda_rel & (sda_oe_n | sda_out);
   // stand-in rom: low byte echoes char, high nibble plane and row
   assign font_row_data = {font_plane, font_row[2:0], font_char};

   osdm_master_model m (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
   osdm_i2c_port dut (.clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .font_char(font_char), .font_row(font_row),
      .font_plane(font_plane), .font_row_data(font_row_data), .page_rd_addr(page_rd_addr),
      .page_rd_data(page_rd_data), .page_rd_attr(page_rd_attr), .busy(busy));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic done(input string nm);
      $display("test %s done", nm);
   endtask

   task automatic idle();
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clock);
      if (busy !== 1'b0) begin
         miscompares++;
         close_out();
      end
   endtask

   task automatic put(input logic [15:0] a, input logic [23:0] d, input int n);
      logic ack;
      m.start();
      m.put_byte(8'hBA, ack);
      `CHK("ack_dev", 1'b1, ack)
      m.put_byte(a[7:0], ack);
      `CHK("ack_lo", 1'b1, ack)
      m.put_byte(a[15:8], ack);
      `CHK("ack_hi", 1'b1, ack)
      for (int i = 0; i < n; i++) begin
         m.put_byte(d[8*i+:8], ack);
         `CHK("ack_data", 1'b1, ack)
      end
      m.stop();
      idle();
   endtask

   task automatic get(input logic [15:0] a, input logic [23:0] e, input int n);
      logic ack;
      logic [7:0] b;
      put(a, 24'h0, 0);
      m.start();
      m.put_byte(8'hBB, ack);
      `CHK("ack_rd", 1'b1, ack)
      for (int i = 0; i < n; i++) begin
         m.get_byte(i == n - 1, b);
         `CHK("rd_byte", e[8*i+:8], b)
      end
      m.stop();
      idle();
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      `CHK("oe_rst", 1'b1, sda_oe_n)
      `CHK("busy_rst", 1'b0, busy)
      `CHK("attr_rst", 4'h0, page_rd_attr)
      done("reset");
   endtask

   task automatic t_addr();
      logic [7:0] ids [4] = '{8'hBA, 8'hB8, 8'h3A, 8'hBE};
      logic ack;
      for (int i = 0; i < 4; i++) begin
         m.start();
         m.put_byte(ids[i], ack);
         `CHK("addr_ack", i == 0, ack)
         m.stop();
         idle();
      end
      done("addr");
   endtask

   task automatic t_page();
      put(16'h81FE, 24'h07A55A, 3);
      put(16'h83FF, 24'h00000C, 1);
      get(16'h81FE, 24'h07A55A, 3);
      get(16'h83FF, 24'h00000C, 1);
      page_rd_addr = 9'h1FF;
      repeat (3) @(negedge clock);
      `CHK("page_entry", 12'hCA5, page_rd_data)
      `CHK("page_attr", 4'hC, page_rd_attr)
      done("page");
   endtask

   task automatic t_font();
      put(16'h8402, 24'h01, 1);
      get(16'h8402, 24'h01, 1);
      put(16'h2FE2, 24'h12, 1);
      get(16'h2FE2, 24'h01BF, 2);
      get(16'h0040, 24'h01, 1);
      get(16'h300A, 24'h0DC0, 2);
      put(16'h8402, 24'h00, 1);
      get(16'h300A, 24'h05C0, 2);
      get(16'h0024, 24'h0000, 2);
      put(16'h4000, 24'h55, 1);
      get(16'h4000, 24'h00, 1);
      done("font");
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (11) @(negedge clock);
      t_reset();
      @(negedge clock);
      resetn = 1'b1;
      repeat (6) @(negedge clock);
      t_addr();
      t_page();
      // display windows stay off, reads are safe
      t_font();
      close_out();
   end

   initial begin
      repeat (100000) @(posedge clock);
      miscompares++;
      close_out();
   end
endmodule
`default_nettype wire
